// File: verilog/wdrs_top.sv
// Our own choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "wdrs_cfg.svh"
module wdrs_top (
    input wire logic clk, // 25 mhz system clock
    input wire logic rst, // main power-on reset, sync, high
    input wire wdrs_pkg::wdrs_bus_s bus, // register request
    input wire wdrs_pkg::wdrs_pins_s pins, // asynchronous levels
    output logic [31:0] rd_data, // read data, cycle after strobe
    output logic irq, // level interrupt
    output logic wdt_reset_req // one-cycle reset request on expiry
);
    import wdrs_pkg::*;

    ////////////////////////////////////////////////////////////////
    // address decode helper
    ////////////////////////////////////////////////////////////////

    // true when the request hits the given offset
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction : hit

    logic wr_ctrl; // write to control
    logic wr_load; // write to reload value
    logic wr_kick; // restart request
    logic wr_pfr; // power-fail status write
    logic wr_prs; // power reset status write
    logic wr_ist; // interrupt status write
    logic wr_imsk; // interrupt mask write
    logic wr_tally; // event tally write

    assign wr_ctrl = bus.wr && hit(bus.addr, `WDRS_OFF_CTRL);
    assign wr_load = bus.wr && hit(bus.addr, `WDRS_OFF_LOAD);
    assign wr_kick = bus.wr && hit(bus.addr, `WDRS_OFF_KICK);
    assign wr_pfr = bus.wr && hit(bus.addr, `WDRS_OFF_PFR);
    assign wr_prs = bus.wr && hit(bus.addr, `WDRS_OFF_PRS);
    assign wr_ist = bus.wr && hit(bus.addr, `WDRS_OFF_INT_STAT);
    assign wr_imsk = bus.wr && hit(bus.addr, `WDRS_OFF_INT_MASK);
    assign wr_tally = bus.wr && hit(bus.addr, `WDRS_OFF_TALLY);

    ////////////////////////////////////////////////////////////////
    // input synchronisers
    ////////////////////////////////////////////////////////////////

    logic [3:0] pin_raw; // pins as a vector
    logic [3:0] sync1; // first stage, read only by sync2
    logic [3:0] sync2; // settled levels

    assign pin_raw = pins;

    // two flops per level; reset levels are slow so no edge is lost
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_sync
            always_ff @(posedge clk) begin
                if (rst) begin
                    sync1[gi] <= 1'b0;
                    sync2[gi] <= 1'b0;
                end else begin
                    sync1[gi] <= pin_raw[gi];
                    sync2[gi] <= sync1[gi];
                end
            end
        end
    endgenerate

    logic sys_s; // system reset, synchronised
    logic nwdt_s; // system reset excluding watchdog
    logic batt_s; // battery domain reset
    logic scan_s; // scan reset pin level

    assign sys_s = sync2[0];
    assign nwdt_s = sync2[1];
    assign batt_s = sync2[2];
    assign scan_s = sync2[3];

    ////////////////////////////////////////////////////////////////
    // watchdog control and counter
    ////////////////////////////////////////////////////////////////

    logic en; // watchdog enable
    logic [31:0] load; // reload value
    logic [31:0] cnt; // watchdog_counter_value
    logic expire; // counter reached zero while enabled

    assign expire = en && (cnt == 32'h0000_0000);

    // control is cleared by power-on, system and non-watchdog resets
    always_ff @(posedge clk) begin
        if (rst || nwdt_s || sys_s) begin
            en <= 1'b0;
            load <= `WDRS_LOAD_RST;
        end else begin
            if (wr_ctrl) begin
                en <= bus.wdata[`WDRS_CTRL_EN];
            end
            if (wr_load) begin
                load <= bus.wdata;
            end
        end
    end

    // counter cleared only by power-on and system reset, never by nwdt alone
    always_ff @(posedge clk) begin
        if (rst || sys_s) begin
            cnt <= 32'h0000_0000;
        end else if (wr_kick || (wr_ctrl && bus.wdata[`WDRS_CTRL_EN] && !en)) begin
            cnt <= load; // restart or fresh enable reloads
        end else if (expire) begin
            cnt <= load; // keep running after a bite
        end else if (en) begin
            cnt <= cnt - 32'h0000_0001;
        end
    end

    // reset request pulse to the system reset generator
    always_ff @(posedge clk) begin
        if (rst) begin
            wdt_reset_req <= 1'b0;
        end else begin
            wdt_reset_req <= expire && !sys_s;
        end
    end

    ////////////////////////////////////////////////////////////////
    // status flags
    ////////////////////////////////////////////////////////////////

    logic fired; // watchdog_fired_flag
    logic batt_flag; // battery_reset_flag
    logic sys_flag; // system_reset_flag
    logic [31:0] tally; // watchdog_event_tally

    // fired flag: only power-on reset or write-one clears it; set wins
    always_ff @(posedge clk) begin
        if (rst) begin
            fired <= 1'b0;
        end else if (expire && !sys_s) begin
            fired <= 1'b1;
        end else if (wr_pfr && bus.wdata[`WDRS_PFR_FIRED]) begin
            fired <= 1'b0;
        end
    end

    // reset-cause flags are sticky while the reset level is seen
    always_ff @(posedge clk) begin
        if (rst) begin
            batt_flag <= 1'b0;
            sys_flag <= 1'b0;
        end else begin
            if (batt_s) begin
                batt_flag <= 1'b1;
            end else if (wr_prs && bus.wdata[`WDRS_PRS_BATT]) begin
                batt_flag <= 1'b0;
            end
            if (sys_s) begin
                sys_flag <= 1'b1;
            end else if (wr_prs && bus.wdata[`WDRS_PRS_SYS]) begin
                sys_flag <= 1'b0;
            end
        end
    end

    // tally: firmware keeps it, only power-on reset clears it
    always_ff @(posedge clk) begin
        if (rst) begin
            tally <= `WDRS_TALLY_RST;
        end else if (wr_tally) begin
            tally <= bus.wdata;
        end
    end

    ////////////////////////////////////////////////////////////////
    // interrupts
    ////////////////////////////////////////////////////////////////

    wdrs_int_t ist; // sticky event status
    wdrs_int_t imsk; // interrupt mask, one enables
    wdrs_int_t ev; // this cycle's events

    assign ev = {batt_s, sys_s, expire && !sys_s};

    // set wins over a write-one clear in the same cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            ist <= 3'h0;
        end else begin
            ist <= ev | (ist & ~(wr_ist ? bus.wdata[2:0] : 3'h0));
        end
    end

    // mask register
    always_ff @(posedge clk) begin
        if (rst) begin
            imsk <= 3'h0;
        end else if (wr_imsk) begin
            imsk <= bus.wdata[2:0];
        end
    end

    // level output from a flop, lags status by one cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(ist & imsk);
        end
    end

    ////////////////////////////////////////////////////////////////
    // read path
    ////////////////////////////////////////////////////////////////

    logic [31:0] next_rd_data; // read mux

    // unmapped reads and reserved bits return zero
    always_comb begin
        next_rd_data = 32'h0000_0000;
        if (bus.rd) begin
            unique case (bus.addr)
                `WDRS_OFF_CTRL: next_rd_data[`WDRS_CTRL_EN] = en;
                `WDRS_OFF_LOAD: next_rd_data = load;
                `WDRS_OFF_COUNT: next_rd_data = cnt;
                `WDRS_OFF_PFR: next_rd_data[`WDRS_PFR_FIRED] = fired;
                `WDRS_OFF_PRS: begin
                    next_rd_data[`WDRS_PRS_BATT] = batt_flag;
                    next_rd_data[`WDRS_PRS_SYS] = sys_flag;
                    next_rd_data[`WDRS_PRS_SCAN] = scan_s;
                end
                `WDRS_OFF_INT_STAT: next_rd_data[2:0] = ist;
                `WDRS_OFF_INT_MASK: next_rd_data[2:0] = imsk;
                `WDRS_OFF_TALLY: next_rd_data = tally;
                default: next_rd_data = 32'h0000_0000;
            endcase
        end
    end

    // data stands only in the cycle after the strobe
    always_ff @(posedge clk) begin
        if (rst) begin
            rd_data <= 32'h0000_0000;
        end else begin
            rd_data <= next_rd_data;
        end
    end

    ////////////////////////////////////////////////////////////////
    // assertions
    ////////////////////////////////////////////////////////////////

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_rsv_bit_zero: assert property (
        bus.rd && hit(bus.addr, `WDRS_OFF_CTRL) |=> rd_data[`WDRS_CTRL_RSV] == 1'b0)
        else $error("reserved control bit read nonzero");

    a_fired_on_expiry: assert property (
        expire && !sys_s |=> fired ##0 wdt_reset_req)
        else $error("expiry did not set fired flag");

    a_count_sys_clear: assert property (
        sys_s |=> cnt == 32'h0000_0000)
        else $error("system reset did not clear counter");

    a_count_nwdt_keep: assert property (
        nwdt_s && !sys_s && !en && !wr_kick && !wr_ctrl |=> cnt == $past(cnt))
        else $error("nwdt reset disturbed counter");

    // a live count must not drop to zero just because nwdt is seen
    a_count_nwdt_live: assert property (
        nwdt_s && !sys_s && !wr_kick && !wr_ctrl && cnt > 32'h0000_0001
        |=> cnt != 32'h0000_0000)
        else $error("nwdt reset cleared counter");

    a_tally_holds: assert property (
        !wr_tally |=> tally == $past(tally))
        else $error("tally changed without a write");

    a_batt_flag_set: assert property (
        batt_s |=> batt_flag)
        else $error("battery reset flag not set");

    a_scan_level_read: assert property (
        bus.rd && hit(bus.addr, `WDRS_OFF_PRS)
        |=> rd_data[`WDRS_PRS_SCAN] == $past(scan_s))
        else $error("scan bit does not follow pin");

    a_sys_flag_set: assert property (
        sys_s |=> sys_flag)
        else $error("system reset flag not set");

    a_fired_sticky: assert property (
        fired && !(wr_pfr && bus.wdata[`WDRS_PFR_FIRED]) |=> fired)
        else $error("fired flag dropped without clear");

    a_irq_follows: assert property (
        |(ist & imsk) |=> irq)
        else $error("interrupt not raised");

    c_expiry: cover property (en ##1 expire);
    c_fired_clear: cover property (fired ##1 wr_pfr ##1 !fired);
    c_sys_then_read: cover property (sys_s ##[1:8] bus.rd);
    c_irq: cover property (irq);
endmodule : wdrs_top
`default_nettype wire

// File: common/wdrs_cfg.svh
// Behaviour
// - control register status bit is reserved, reads zero
// - watchdog event shows at bit 5 of status
// - system reset clears counter; excluding-watchdog reset doesn't
// - event tally clears on power-on reset only
// - battery reset flag bit 5 set by battery reset, held until cleared by writing
// - scan reset bit shows present pin level
// - bit 7 read-only pin level, even during scan
// - system reset flag bit 6, cleared by writing
`ifndef WDRS_CFG_SVH
`define WDRS_CFG_SVH
// register offsets (byte addresses)
`define WDRS_OFF_CTRL 8'h00
`define WDRS_OFF_LOAD 8'h04
`define WDRS_OFF_COUNT 8'h08
`define WDRS_OFF_KICK 8'h0c
`define WDRS_OFF_PFR 8'h10
`define WDRS_OFF_PRS 8'h14
`define WDRS_OFF_INT_STAT 8'h18
`define WDRS_OFF_INT_MASK 8'h1c
`define WDRS_OFF_TALLY 8'h28
// field positions
`define WDRS_CTRL_EN 0
`define WDRS_CTRL_RSV 2
`define WDRS_PFR_FIRED 5
`define WDRS_PRS_BATT 5
`define WDRS_PRS_SYS 6
`define WDRS_PRS_SCAN 7
`define WDRS_INT_FIRED 0
`define WDRS_INT_SYS 1
`define WDRS_INT_BATT 2
// reset values
`define WDRS_LOAD_RST 32'h0000_ffff
`define WDRS_TALLY_RST 32'h0000_0000
`endif

// File: common/wdrs_pkg.sv
package wdrs_pkg;
    // one register bus request from firmware
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } wdrs_bus_s;
    // reset and pin levels from outside the clock domain
    typedef struct packed {
        logic scan_pin;
        logic batt_rst;
        logic sys_nwdt_rst;
        logic sys_rst;
    } wdrs_pins_s;
    typedef logic [2:0] wdrs_int_t;
endpackage : wdrs_pkg

// File: testbench/test_wdrs_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "wdrs_cfg.svh"
module test_wdrs_top;
    import wdrs_pkg::*;
    localparam logic [31:0] all = 32'hffff_ffff; // full compare mask
    logic clk = 1'b0; // 25 mhz bench clock
    logic rst = 1'b1; // power-on reset
    wdrs_bus_s bus = '0; // register request
    wdrs_pins_s pins = '0; // reset and pin levels
    logic [31:0] rd_data; // read data
    logic irq; // level interrupt
    logic wdt_reset_req; // expiry pulse
    int errors = 0; // mismatches
    int n_tests = 0; // comparisons
    logic [31:0] eq[$]; // expected read data
    logic [31:0] mq[$]; // mask, zero means expect nonzero
    logic [7:0] aq[$]; // address of each read
    logic rd_q = 1'b0; // a read was taken at the last edge
    logic [31:0] seed = 32'hea7a10ab; // lfsr state
    logic [31:0] tally = 32'h0; // model of the event tally
    logic [31:0] m; // popped mask
    logic [31:0] e; // popped expectation
    logic i1; // irq with mask cleared
    logic s; // random scan pin level

    // free running clock, period 40 ns
    always #20 clk = ~clk;

    wdrs_top dut (
        .clk(clk),
        .rst(rst),
        .bus(bus),
        .pins(pins),
        .rd_data(rd_data),
        .irq(irq),
        .wdt_reset_req(wdt_reset_req)
    );

    ////////////////////////////////////////////////////////////////////////
    // closing report, reached from the sequence and from the hang guard
    task automatic print_verdict;
        if (errors == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : print_verdict

    // one comparison, four-state so an unknown never matches
    task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // galois lfsr, the only source of random values
    function automatic logic [31:0] lfsr();
        seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h8020_0003 : 32'h0);
        return seed;
    endfunction : lfsr

    ////////////////////////////////////////////////////////////////////////
    // bus cycles: one strobe cycle, then idle, so no signal is set twice
    task automatic wr(logic [7:0] a, logic [31:0] d);
        @(posedge clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus.wr <= 1'b0;
    endtask : wr

    // read: the expectation is noted now, compared when data appear
    task automatic rd(logic [7:0] a, logic [31:0] x, logic [31:0] k);
        @(posedge clk);
        bus <= '{addr: a, wdata: lfsr(), wr: 1'b0, rd: 1'b1};
        eq.push_back(x);
        mq.push_back(k);
        aq.push_back(a);
        @(posedge clk);
        bus.rd <= 1'b0;
    endtask : rd

    // hold reset levels long enough to pass the two-flop synchroniser
    task automatic lvl(logic [3:0] v);
        @(posedge clk);
        pins <= v;
        repeat (5) @(posedge clk);
    endtask : lvl

    // bounded wait for the expiry pulse, then confirm it lasted one cycle
    task automatic wait_fire;
        int k;
        k = 0;
        while (wdt_reset_req !== 1'b1 && k < 50) begin
            @(posedge clk) #1;
            k++;
        end
        if (wdt_reset_req !== 1'b1) begin
            $display("Error wdt_reset_req expected 1 seen %b", wdt_reset_req);
            errors++;
            print_verdict();
        end else begin
            @(posedge clk) #1;
            check("wdt_reset_req", {31'h0, wdt_reset_req}, 32'h0);
        end
    endtask : wait_fire

    ////////////////////////////////////////////////////////////////////////
    // read data stand in the cycle after the strobe and only there
    always @(posedge clk) begin
        rd_q <= bus.rd;
        if (rd_q) begin
            m = mq.pop_front();
            e = eq.pop_front();
            if (m == 32'h0)
                check($sformatf("rd_data at %h", aq.pop_front()), {31'h0, rd_data != 0}, 32'h1);
            else
                check($sformatf("rd_data at %h", aq.pop_front()), rd_data & m, e & m);
        end
    end

    // hang guard: a run that overstays counts as a mismatch
    initial begin
        repeat (20000) @(posedge clk);
        $display("Error run expected end seen hang");
        errors++;
        print_verdict();
    end

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        rd(`WDRS_OFF_TALLY, 32'h0, all);
        rd(`WDRS_OFF_LOAD, `WDRS_LOAD_RST, all);
        wr(`WDRS_OFF_CTRL, 32'h4);
        rd(`WDRS_OFF_CTRL, 32'h0, 32'h4);
        wr(8'h40, lfsr());
        rd(8'h40, 32'h0, all);
        tally = lfsr();
        wr(`WDRS_OFF_TALLY, tally);
        rd(`WDRS_OFF_TALLY, tally, all);
        // short reload so the watchdog expires quickly
        wr(`WDRS_OFF_LOAD, 32'h5);
        wr(`WDRS_OFF_CTRL, 32'h1);
        wait_fire();
        wr(`WDRS_OFF_CTRL, 32'h0);
        rd(`WDRS_OFF_PFR, 32'h20, 32'h20);
        rd(`WDRS_OFF_INT_STAT, 32'h1, 32'h1);
        // a one in the mask lets the matching status bit through
        wr(`WDRS_OFF_INT_MASK, 32'h0);
        repeat (3) @(posedge clk) #1;
        i1 = irq;
        wr(`WDRS_OFF_INT_MASK, 32'h7);
        repeat (3) @(posedge clk) #1;
        check("irq masked", {31'h0, i1}, 32'h0);
        check("irq unmasked", {31'h0, irq}, 32'h1);
        wr(`WDRS_OFF_INT_STAT, 32'h7);
        repeat (3) @(posedge clk) #1;
        check("irq clear", {31'h0, irq}, 32'h0);
        // reset excluding the watchdog keeps flag and tally
        lvl(4'b0010);
        lvl(4'b0000);
        rd(`WDRS_OFF_PFR, 32'h20, 32'h20);
        rd(`WDRS_OFF_TALLY, tally, all);
        rd(`WDRS_OFF_PRS, 32'h0, 32'h60);
        // firmware start-up: clear the flag, then bump the tally
        wr(`WDRS_OFF_PFR, 32'h20);
        rd(`WDRS_OFF_PFR, 32'h0, 32'h20);
        tally = tally + 32'h1;
        wr(`WDRS_OFF_TALLY, tally);
        rd(`WDRS_OFF_TALLY, tally, all);
        // counter survives the reset that excludes the watchdog
        wr(`WDRS_OFF_LOAD, 32'h1000);
        wr(`WDRS_OFF_CTRL, 32'h1);
        // kick reloads, one decrement before the read samples it
        wr(`WDRS_OFF_KICK, lfsr());
        rd(`WDRS_OFF_COUNT, 32'h0000_0fff, all);
        lvl(4'b0010);
        lvl(4'b0000);
        rd(`WDRS_OFF_CTRL, 32'h0, 32'h1);
        rd(`WDRS_OFF_COUNT, 32'h0, 32'h0);
        lvl(4'b0001);
        lvl(4'b0000);
        rd(`WDRS_OFF_COUNT, 32'h0, all);
        rd(`WDRS_OFF_LOAD, `WDRS_LOAD_RST, all);
        rd(`WDRS_OFF_PRS, 32'h40, 32'h60);
        rd(`WDRS_OFF_INT_STAT, 32'h2, 32'h2);
        wr(`WDRS_OFF_PRS, 32'h40);
        rd(`WDRS_OFF_PRS, 32'h0, 32'h40);
        // battery domain reset
        lvl(4'b0100);
        lvl(4'b0000);
        rd(`WDRS_OFF_PRS, 32'h20, 32'h60);
        rd(`WDRS_OFF_INT_STAT, 32'h4, 32'h4);
        wr(`WDRS_OFF_PRS, 32'h20);
        rd(`WDRS_OFF_PRS, 32'h0, 32'h20);
        // scan pin level, writes to bit 7 must not stick
        for (int i = 0; i < 6; i++) begin
            s = 1'(lfsr() >> 7);
            lvl({s, 3'b000});
            wr(`WDRS_OFF_PRS, s ? 32'h0 : 32'h80);
            rd(`WDRS_OFF_PRS, {24'h0, s, 7'h0}, 32'h80);
        end
        // fire once more so the power-on reset has a flag to clear
        wr(`WDRS_OFF_LOAD, 32'h5);
        wr(`WDRS_OFF_CTRL, 32'h1);
        wait_fire();
        // power-on reset in mid-run clears flag and tally
        @(posedge clk);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rd(`WDRS_OFF_TALLY, 32'h0, all);
        rd(`WDRS_OFF_PFR, 32'h0, 32'h20);
        repeat (4) @(posedge clk);
        print_verdict();
    end
endmodule : test_wdrs_top
`default_nettype wire
